// File: src/cmai_pkg.sv
`default_nettype none
package cmai_pkg;
  // ----------------------------------------
  // Instruction word layout
  // ----------------------------------------
  localparam int          INSN_W      = 48;
  localparam int          OP_LO       = 45;
  localparam logic [2:0]  OP_REGMOD   = 3'h2;
  localparam logic [2:0]  OP_IMMMOD   = 3'h3;
  localparam int          F_U         = 44;
  localparam int          F_I_LO      = 41;
  localparam int          CMP_W       = 23;
  localparam int          T3_M_LO     = 38;
  localparam int          T3_CONDITION_FIELD_LO  = 33;
  localparam int          T3_G        = 32;
  localparam int          T3_D        = 31;
  localparam int          T3_L        = 30;
  localparam int          T3_UREG_LO  = 23;
  localparam int          T4_DATA_LO  = 35;
  localparam int          T4_CONDITION_FIELD_LO  = 30;
  localparam int          T4_G        = 29;
  localparam int          T4_D        = 28;
  localparam int          T4_DREG_LO  = 24;
  localparam logic [4:0]  CONDITION_FIELD_ALWAYS = 5'h1f;
  localparam logic [6:0]  CUREG_XOR   = 7'h40;
  localparam logic [2:0]  UREG_IDX_GP = 3'h1;
  localparam logic [2:0]  UREG_MOD_GP = 3'h2;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0]  OFF_MODE    = 8'h00;
  localparam logic [7:0]  OFF_STATUS  = 8'h04;
  localparam logic [7:0]  OFF_COUNT   = 8'h08;
  localparam logic [7:0]  OFF_INDEX   = 8'h40;
  localparam logic [7:0]  OFF_MODIFY  = 8'h80;
  localparam int          MODE_DUAL   = 0;
  localparam int          MODE_BC1    = 1;
  localparam int          MODE_BC9    = 2;
  localparam int          ST_CONFLICT = 0;
  localparam int          ST_LAST_X   = 1;
  localparam int          ST_LAST_Y   = 2;
  localparam logic [2:0]  MODE_RST    = 3'h0;
  localparam logic [31:0] REG_RST     = 32'h0;

  typedef struct packed {
    logic        valid;
    logic        pm;
    logic        wr;
    logic        lw;
    logic        bcast;
    logic [6:0]  regc;
    logic        cmp_en;
    logic [31:0] addr;
  } cmai_lane_t;

  function automatic logic [31:0] cmai_sext6(input logic [5:0] d);
    return {{26{d[5]}}, d};
  endfunction : cmai_sext6

  function automatic logic [6:0] cmai_cureg(input logic [6:0] r);
    return r ^ CUREG_XOR;
  endfunction : cmai_cureg
endpackage : cmai_pkg
`default_nettype wire

// File: src/cmai_lane_addr.sv
`default_nettype none
module cmai_lane_addr #(
  parameter int W = 32
) (
  input  wire logic [W-1:0] i_index,
  input  wire logic [W-1:0] i_modify,
  input  wire logic         i_pre,
  input  wire logic         i_plus_one,
  output logic      [W-1:0] o_addr,
  output logic      [W-1:0] o_update
);
  if (W < 2) begin : g_chk
    $error("cmai_lane_addr: W too small");
  end

  logic [W-1:0] base;

  // The lane offset is applied before any modify
  assign base     = i_index + W'(i_plus_one);
  // Pre-modify offsets the address; post-modify drives the index
  assign o_addr   = i_pre ? base + i_modify : base;
  assign o_update = i_index + i_modify;
endmodule : cmai_lane_addr
`default_nettype wire

// File: src/cmai_condition_field_eval.sv
`default_nettype none
module cmai_condition_field_eval #(
  parameter int NCOND = 32
) (
  input  wire logic [4:0]       i_code,
  input  wire logic [NCOND-1:0] i_flags,
  output logic                  o_true
);
  if (NCOND != 32) begin : g_chk
    $error("cmai_condition_field_eval: NCOND must be 32");
  end

  // The all-ones code never depends on the flags
  assign o_true = (i_code == cmai_pkg::CONDITION_FIELD_ALWAYS) | i_flags[i_code];
endmodule : cmai_condition_field_eval
`default_nettype wire

// File: src/cmai_top.sv
`default_nettype none
module cmai_top (
  input  wire logic                I_CLK,
  input  wire logic                I_RESET_N,
  input  wire logic                I_PSEL,
  input  wire logic                I_PENABLE,
  input  wire logic                I_PWRITE,
  input  wire logic [7:0]          I_PADDR,
  input  wire logic [31:0]         I_PWDATA,
  output logic      [31:0]         O_PRDATA,
  output logic                     O_PREADY,
  output logic                     O_PSLVERR,
  input  wire logic                I_INSN_VALID,
  input  wire logic [47:0]         I_INSN,
  input  wire logic [31:0]         I_CONDITION_FIELD_X,
  input  wire logic [31:0]         I_CONDITION_FIELD_Y,
  output cmai_pkg::cmai_lane_t     O_LANE_X,
  output cmai_pkg::cmai_lane_t     O_LANE_Y,
  output logic      [22:0]         O_COMPUTE
);
  import cmai_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [2:0]        mode;
    logic [2:0]        status;
    logic [31:0]       count;
    logic [15:0][31:0] idx;
    logic [15:0][31:0] mdf;
    cmai_lane_t        lx;
    cmai_lane_t        ly;
    logic [22:0]       compute;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } cmai_state_t;

  cmai_state_t s_r;
  cmai_state_t s_nxt;
  logic [1:0]  rst_sync_r;
  logic        rst_n;

  // ----------------------------------------
  // Reset release
  // ----------------------------------------
  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rst_sync_r <= 2'h0;
    end else begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_r[1];

  // ----------------------------------------
  // Register map helpers
  // ----------------------------------------
  function automatic logic reg_mapped(input logic [7:0] a);
    logic ok;
    ok = (a == OFF_MODE) | (a == OFF_STATUS) | (a == OFF_COUNT);
    ok = ok | ((a[1:0] == 2'h0) & (a[7:6] == OFF_INDEX[7:6]));
    ok = ok | ((a[1:0] == 2'h0) & (a[7:6] == OFF_MODIFY[7:6]));
    return ok;
  endfunction : reg_mapped

  function automatic logic [31:0] reg_read(input cmai_state_t st, input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0;
    if (a == OFF_MODE) begin
      d[2:0] = st.mode;
    end else if (a == OFF_STATUS) begin
      d[2:0] = st.status;
    end else if (a == OFF_COUNT) begin
      d = st.count;
    end else if (reg_mapped(a) && a[7:6] == OFF_INDEX[7:6]) begin
      d = st.idx[a[5:2]];
    end else if (reg_mapped(a) && a[7:6] == OFF_MODIFY[7:6]) begin
      d = st.mdf[a[5:2]];
    end
    return d;
  endfunction : reg_read

  // ----------------------------------------
  // Instruction decode
  // ----------------------------------------
  logic        t3_c;
  logic        t4_c;
  logic        go_c;
  logic        post_c;
  logic        g_c;
  logic        wr_c;
  logic        lw_c;
  logic        bc_c;
  logic        cx_c;
  logic        cy_c;
  logic        ex_x_c;
  logic        ex_y_c;
  logic        cmp_on_c;
  logic        conflict_c;
  logic        apb_setup_c;
  logic        apb_wr_c;
  logic [3:0]  sel_c;
  logic [4:0]  code_c;
  logic [6:0]  reg_c;
  logic [31:0] idx_c;
  logic [31:0] mod_c;
  logic [31:0] addr_x_c;
  logic [31:0] addr_y_c;
  logic [31:0] upd_c;
  cmai_lane_t  lane_x_c;
  cmai_lane_t  lane_y_c;

  assign t3_c     = I_INSN[OP_LO +: 3] == OP_REGMOD;
  assign t4_c     = I_INSN[OP_LO +: 3] == OP_IMMMOD;
  assign go_c     = I_INSN_VALID & (t3_c | t4_c);
  assign post_c   = I_INSN[F_U];
  assign g_c      = t3_c ? I_INSN[T3_G] : I_INSN[T4_G];
  assign wr_c     = t3_c ? I_INSN[T3_D] : I_INSN[T4_D];
  assign lw_c     = t3_c & I_INSN[T3_L];
  assign code_c   = t3_c ? I_INSN[T3_CONDITION_FIELD_LO +: 5] : I_INSN[T4_CONDITION_FIELD_LO +: 5];
  // Memory select also picks the generator: data uses 0-7, program 8-15
  assign sel_c    = {g_c, I_INSN[F_I_LO +: 3]};
  assign idx_c    = s_r.idx[sel_c];
  assign mod_c    = t3_c ? s_r.mdf[{g_c, I_INSN[T3_M_LO +: 3]}]
                         : cmai_sext6(I_INSN[T4_DATA_LO +: 6]);
  assign reg_c    = t3_c ? I_INSN[T3_UREG_LO +: 7] : {3'h0, I_INSN[T4_DREG_LO +: 4]};
  assign cmp_on_c = I_INSN[CMP_W-1:0] != 23'h0;
  // Broadcast only applies to reads; a write from both lanes would collide
  assign bc_c     = ~wr_c & ((s_r.mode[MODE_BC1] & (sel_c == 4'h1))
                           | (s_r.mode[MODE_BC9] & (sel_c == 4'h9)));
  assign ex_x_c   = go_c & cx_c;
  assign ex_y_c   = go_c & s_r.mode[MODE_DUAL] & cy_c;
  // Flag only: the transfer still runs, software sees the misuse
  assign conflict_c = go_c & t3_c & (reg_c[3] == g_c)
                    & ((reg_c[6:4] == UREG_IDX_GP) | (reg_c[6:4] == UREG_MOD_GP));

  cmai_condition_field_eval #(.NCOND(32)) u_condition_field_x (
    .i_code  (code_c),
    .i_flags (I_CONDITION_FIELD_X),
    .o_true  (cx_c)
  );

  cmai_condition_field_eval #(.NCOND(32)) u_condition_field_y (
    .i_code  (code_c),
    .i_flags (I_CONDITION_FIELD_Y),
    .o_true  (cy_c)
  );

  cmai_lane_addr #(.W(32)) u_addr_x (
    .i_index    (idx_c),
    .i_modify   (mod_c),
    .i_pre      (~post_c),
    .i_plus_one (1'b0),
    .o_addr     (addr_x_c),
    .o_update   (upd_c)
  );

  cmai_lane_addr #(.W(32)) u_addr_y (
    .i_index    (idx_c),
    .i_modify   (mod_c),
    .i_pre      (~post_c),
    .i_plus_one (~bc_c),
    .o_addr     (addr_y_c),
    .o_update   ()
  );

  always_comb begin
    lane_x_c        = '0;
    lane_x_c.valid  = ex_x_c;
    lane_x_c.pm     = g_c;
    lane_x_c.wr     = wr_c;
    lane_x_c.lw     = lw_c;
    lane_x_c.bcast  = bc_c;
    lane_x_c.regc   = reg_c;
    lane_x_c.cmp_en = ex_x_c & cmp_on_c;
    lane_x_c.addr   = addr_x_c;
    lane_y_c        = lane_x_c;
    lane_y_c.valid  = ex_y_c;
    lane_y_c.regc   = cmai_cureg(reg_c);
    lane_y_c.cmp_en = ex_y_c & cmp_on_c;
    lane_y_c.addr   = addr_y_c;
  end

  // ----------------------------------------
  // APB slave and next state
  // ----------------------------------------
  assign apb_setup_c = I_PSEL & ~I_PENABLE;
  assign apb_wr_c    = I_PSEL & I_PENABLE & s_r.pready & I_PWRITE & reg_mapped(I_PADDR);

  always_comb begin
    s_nxt         = s_r;
    s_nxt.pready  = apb_setup_c;
    s_nxt.pslverr = apb_setup_c & ~reg_mapped(I_PADDR);
    if (apb_setup_c) begin
      s_nxt.prdata = reg_read(s_r, I_PADDR);
    end
    if (apb_wr_c) begin
      if (I_PADDR == OFF_MODE) begin
        s_nxt.mode = I_PWDATA[2:0];
      end else if (I_PADDR == OFF_STATUS) begin
        if (I_PWDATA[ST_CONFLICT]) begin
          s_nxt.status[ST_CONFLICT] = 1'b0;
        end
      end else if (I_PADDR[7:6] == OFF_INDEX[7:6]) begin
        s_nxt.idx[I_PADDR[5:2]] = I_PWDATA;
      end else if (I_PADDR[7:6] == OFF_MODIFY[7:6]) begin
        s_nxt.mdf[I_PADDR[5:2]] = I_PWDATA;
      end
    end
    // Hardware events come after the software write so the set wins
    if (conflict_c) begin
      s_nxt.status[ST_CONFLICT] = 1'b1;
    end
    if (go_c) begin
      s_nxt.status[ST_LAST_X] = ex_x_c;
      s_nxt.status[ST_LAST_Y] = ex_y_c;
    end
    if (ex_x_c | ex_y_c) begin
      s_nxt.count = s_r.count + 32'h1;
    end
    // Index write-back only when post-modify and some lane executed
    if (go_c & post_c & (ex_x_c | ex_y_c)) begin
      s_nxt.idx[sel_c] = upd_c;
    end
    s_nxt.lx      = lane_x_c;
    s_nxt.ly      = lane_y_c;
    s_nxt.compute = I_INSN[CMP_W-1:0];
  end

  always_ff @(posedge I_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      s_r <= '0;
    end else if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign O_PRDATA  = s_r.prdata;
  assign O_PREADY  = s_r.pready;
  assign O_PSLVERR = s_r.pslverr;
  assign O_LANE_X  = s_r.lx;
  assign O_LANE_Y  = s_r.ly;
  assign O_COMPUTE = s_r.compute;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!rst_n);

  sequence seq_post_issue;
    go_c && post_c && (ex_x_c || ex_y_c);
  endsequence

  sequence seq_pre_issue;
    go_c && !post_c && !apb_wr_c;
  endsequence

  chk_post_addr_out: assert property (go_c && post_c && ex_x_c |=>
    O_LANE_X.addr == $past(idx_c))
    else $error("post-modify address is not the old index");

  chk_post_wb_value: assert property (seq_post_issue |=>
    s_r.idx[$past(sel_c)] == $past(upd_c))
    else $error("post-modify write-back missing");

  chk_pre_no_wb: assert property (seq_pre_issue |=>
    s_r.idx[$past(sel_c)] == $past(idx_c))
    else $error("pre-modify changed the index");

  chk_condition_field_false_x: assert property (go_c && !cx_c |=>
    !O_LANE_X.valid && !O_LANE_X.cmp_en)
    else $error("primary lane ran on a false condition");

  chk_single_lane: assert property (!s_r.mode[MODE_DUAL] |=>
    !O_LANE_Y.valid && !O_LANE_Y.cmp_en)
    else $error("secondary lane active in single-lane mode");

  chk_lane_offset: assert property (ex_x_c && ex_y_c && !bc_c |=>
    O_LANE_Y.addr == 32'(O_LANE_X.addr + 32'h1))
    else $error("secondary address is not primary plus one");

  chk_bcast_addr: assert property (ex_y_c && ex_x_c && bc_c |=>
    O_LANE_Y.addr == O_LANE_X.addr && O_LANE_Y.bcast)
    else $error("broadcast lanes differ");

  chk_cureg_pair: assert property (ex_x_c && ex_y_c |=>
    O_LANE_Y.regc == cmai_cureg(O_LANE_X.regc))
    else $error("secondary register not complementary");

  chk_nop_compute: assert property (go_c && !cmp_on_c |=>
    !O_LANE_X.cmp_en && !O_LANE_Y.cmp_en)
    else $error("compute enabled for an empty field");

  chk_always_true: assert property (go_c && code_c == CONDITION_FIELD_ALWAYS |=>
    O_LANE_X.valid && (O_LANE_Y.valid == $past(s_r.mode[MODE_DUAL])))
    else $error("always-true code did not execute");

  chk_long_word: assert property (go_c && t3_c && I_INSN[T3_L] && ex_x_c |=>
    O_LANE_X.lw)
    else $error("long-word override lost");

  chk_dreg_pair: assert property (ex_x_c && ex_y_c && t4_c |=>
    O_LANE_Y.regc[3:0] == O_LANE_X.regc[3:0] && O_LANE_Y.regc[6] != O_LANE_X.regc[6])
    else $error("secondary data register not complementary");

  chk_other_opcode: assert property (I_INSN_VALID && !t3_c && !t4_c |=>
    !O_LANE_X.valid && !O_LANE_Y.valid)
    else $error("foreign opcode started a transfer");

  chk_condition_field_false_y: assert property (go_c && !cy_c |=>
    !O_LANE_Y.valid && !O_LANE_Y.cmp_en)
    else $error("secondary lane ran on a false condition");
endmodule : cmai_top
`default_nettype wire

// File: verif/cmai_mem_model.sv
`default_nettype none
module cmai_mem_model (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire cmai_pkg::cmai_lane_t i_lane_x,
  input  wire cmai_pkg::cmai_lane_t i_lane_y,
  output logic                [7:0] o_pm_count,
  output logic                [7:0] o_dm_count
);
  import cmai_pkg::*;
  // ----------------------------------------
  // Access counting
  // ----------------------------------------
  // Read data is not modelled: the block has no read-data input to feed
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      o_pm_count <= 8'h00;
      o_dm_count <= 8'h00;
    end else begin
      o_pm_count <= o_pm_count + 8'(i_lane_x.valid & i_lane_x.pm)
                    + 8'(i_lane_y.valid & i_lane_y.pm);
      o_dm_count <= o_dm_count + 8'(i_lane_x.valid & !i_lane_x.pm)
                    + 8'(i_lane_y.valid & !i_lane_y.pm);
    end
  end
endmodule : cmai_mem_model
`default_nettype wire

// File: verif/cmai_top_test.sv
`default_nettype none
module cmai_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cmai_pkg::*;
  logic        clk;
  logic        rst_n;
  logic        psel;
  logic        pen;
  logic        pwr;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        iv;
  logic [47:0] insn;
  logic [31:0] cx;
  logic [31:0] cy;
  cmai_lane_t  lx;
  cmai_lane_t  ly;
  logic [22:0] cmp;
  logic [7:0]  pmc;
  logic [7:0]  dmc;
  int          miscompares;
  int          checked;

  cmai_top dut_u (.I_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
    .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
    .O_PREADY(pready), .O_PSLVERR(pslverr), .I_INSN_VALID(iv), .I_INSN(insn),
    .I_CONDITION_FIELD_X(cx), .I_CONDITION_FIELD_Y(cy), .O_LANE_X(lx), .O_LANE_Y(ly), .O_COMPUTE(cmp));
  cmai_mem_model mem_u (.i_clk(clk), .i_reset_n(rst_n), .i_lane_x(lx), .i_lane_y(ly),
    .o_pm_count(pmc), .o_dm_count(dmc));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic stop_test;
    if (miscompares == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask : chk

  task automatic chkb(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      miscompares++;
      $display("BAD %s exp %b got %b", n, e, g);
    end
  endtask : chkb

  // Request held until pready is sampled high at a rising edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (n == 20) begin
      miscompares++;
      stop_test();
    end
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask : apb

  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wreg

  task automatic rreg(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    chk(n, x, r);
  endtask : rreg

  // Outputs are registered: look at them just after the edge that takes the word
  task automatic ins(input logic [47:0] w);
    @(posedge clk);
    iv   <= 1'b1;
    insn <= w;
    @(posedge clk);
    iv <= 1'b0;
    #1;
  endtask : ins

  // f = {update, memory select, direction, long word}
  function automatic logic [47:0] t3(logic [3:0] f, logic [2:0] i, logic [2:0] m,
                                     logic [4:0] c, logic [6:0] r, logic [22:0] x);
    return {OP_REGMOD, f[3], i, m, c, f[2:0], r, x};
  endfunction : t3

  // f = {update, memory select, direction}
  function automatic logic [47:0] t4(logic [2:0] f, logic [2:0] i, logic [5:0] v,
                                     logic [4:0] c, logic [3:0] r);
    return {OP_IMMMOD, f[2], i, v, c, f[1:0], r, 1'b0, 23'h0};
  endfunction : t4

  // ----------------------------------------
  // Stimulus
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  initial begin
    logic [31:0] r;
    logic        e;
    logic [47:0] w;
    miscompares = 0;
    checked = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    iv = 1'b0;
    insn = 48'h0;
    cx = 32'h0;
    cy = 32'h0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    rreg("mode rst", OFF_MODE, 32'h0);
    rreg("count rst", OFF_COUNT, 32'h0);
    apb(1'b0, 8'h0c, 32'h0, r, e);
    chkb("unmapped err", 1'b1, e);
    chk("unmapped data", 32'h0, r);
    wreg(OFF_INDEX + 8'h0c, 32'h100);
    wreg(OFF_MODIFY + 8'h14, 32'h10);
    wreg(OFF_INDEX + 8'h24, 32'h200);
    wreg(OFF_MODIFY + 8'h28, 32'h8);
    wreg(OFF_INDEX + 8'h04, 32'h300);
    // Register 01 lies outside both generators
    ins(t3(4'h0, 3'h3, 3'h5, CONDITION_FIELD_ALWAYS, 7'h01, 23'h0));
    chk("x addr pre", 32'h110, lx.addr);
    chkb("x valid", 1'b1, lx.valid);
    chkb("x cmp off", 1'b0, lx.cmp_en);
    chk("x regc", 32'h01, 32'(lx.regc));
    chkb("y single", 1'b0, ly.valid);
    rreg("i3 pre", OFF_INDEX + 8'h0c, 32'h100);
    ins(t3(4'h8, 3'h3, 3'h5, CONDITION_FIELD_ALWAYS, 7'h01, 23'h123));
    chk("x addr post", 32'h100, lx.addr);
    chkb("x cmp on", 1'b1, lx.cmp_en);
    chk("compute", 32'h123, 32'(cmp));
    rreg("i3 post", OFF_INDEX + 8'h0c, 32'h110);
    ins(t3(4'h7, 3'h1, 3'h2, CONDITION_FIELD_ALWAYS, 7'h02, 23'h0));
    chk("pm addr", 32'h208, lx.addr);
    chkb("pm sel", 1'b1, lx.pm);
    chkb("pm wr", 1'b1, lx.wr);
    chkb("lw", 1'b1, lx.lw);
    ins(t3(4'h8, 3'h3, 3'h5, 5'h05, 7'h01, 23'h7));
    chkb("false valid", 1'b0, lx.valid);
    chkb("false cmp", 1'b0, lx.cmp_en);
    rreg("i3 held", OFF_INDEX + 8'h0c, 32'h110);
    cx <= 32'h20;
    ins(t3(4'h0, 3'h3, 3'h5, 5'h05, 7'h01, 23'h0));
    chkb("true valid", 1'b1, lx.valid);
    wreg(OFF_MODE, 32'h1);
    rreg("mode dual", OFF_MODE, 32'h1);
    ins(t3(4'h0, 3'h3, 3'h5, CONDITION_FIELD_ALWAYS, 7'h01, 23'h1));
    chk("x addr dual", 32'h120, lx.addr);
    chk("y addr pre", 32'h121, ly.addr);
    chkb("y cmp", 1'b1, ly.cmp_en);
    chk("y regc", 32'h41, 32'(ly.regc));
    ins(t3(4'h8, 3'h3, 3'h5, CONDITION_FIELD_ALWAYS, 7'h01, 23'h1));
    chk("y addr post", 32'h111, ly.addr);
    rreg("i3 dual", OFF_INDEX + 8'h0c, 32'h120);
    ins(t3(4'h0, 3'h3, 3'h5, 5'h05, 7'h01, 23'h1));
    chkb("x own condition_field", 1'b1, lx.valid);
    chkb("y own condition_field", 1'b0, ly.valid);
    chkb("y cmp condition_field", 1'b0, ly.cmp_en);
    rreg("status lanes", OFF_STATUS, 32'h2);
    wreg(OFF_MODE, 32'h3);
    ins(t3(4'h0, 3'h1, 3'h5, CONDITION_FIELD_ALWAYS, 7'h01, 23'h0));
    chk("y addr bcast", 32'h310, ly.addr);
    chkb("bcast", 1'b1, ly.bcast);
    wreg(OFF_MODE, 32'h5);
    ins(t3(4'h4, 3'h1, 3'h2, CONDITION_FIELD_ALWAYS, 7'h02, 23'h0));
    chk("x addr bcast9", 32'h208, lx.addr);
    chk("y addr bcast9", 32'h208, ly.addr);
    chkb("bcast9", 1'b1, ly.bcast);
    wreg(OFF_MODE, 32'h1);
    ins(t4(3'h0, 3'h3, 6'h3e, CONDITION_FIELD_ALWAYS, 4'h5));
    chk("x addr imm", 32'h11e, lx.addr);
    chk("y addr imm", 32'h11f, ly.addr);
    chk("y dreg", 32'h45, 32'(ly.regc));
    w = t3(4'h0, 3'h3, 3'h5, CONDITION_FIELD_ALWAYS, 7'h01, 23'h0);
    w[47:45] = 3'h1;
    ins(w);
    chkb("x other op", 1'b0, lx.valid);
    chkb("y other op", 1'b0, ly.valid);
    rreg("count", OFF_COUNT, 32'ha);
    chk("pm count", 32'h3, 32'(pmc));
    chk("dm count", 32'hc, 32'(dmc));
    stop_test();
  end
endmodule : cmai_top_test
`default_nettype wire
